// ===== include/ufb_defs.vh
// Constants for the UART FIFO port and fractional baud block
`ifndef UFB_DEFS_VH
`define UFB_DEFS_VH

// ==========================================================
// Address map (byte address, 11 bits, 0x000..0x7FF)
`define UFB_ADDR_W 11
`define UFB_CH_BIT 10
`define UFB_PAGE_REGS 2'h0
`define UFB_PAGE_FIFO 2'h1
`define UFB_OFF_HOLD 8'h00
`define UFB_OFF_DIV_LOW 8'h08
`define UFB_OFF_DIV_HIGH 8'h09
`define UFB_OFF_DIV_FRAC 8'h0A
`define UFB_OFF_MODEM_CTL 8'h0B

// ==========================================================
// Reset values
`define UFB_RST_DIV_LOW 8'h01
`define UFB_RST_DIV_HIGH 8'h00
`define UFB_RST_DIV_FRAC 4'h0
`define UFB_RST_MODEM_CTL 8'h00

// ==========================================================
// Field positions and sizes
`define UFB_MCR_PRESCALE_BIT 7
`define UFB_PRESCALE_LAST 2'h3
`define UFB_FRAC_W 4
`define UFB_FRAC_STEP 21'h000010
`define UFB_FIFO_DEPTH 9'h100
`define UFB_FIFO_AW 8
`define UFB_LAST_BYTE_LANE 2'h3
`define UFB_LAST_HALF 2'h1

`endif

// ===== verilog/ufb_ram.v
// Simple dual-port FIFO storage with registered read data
`timescale 1ns/1ps
`default_nettype none

module ufb_ram #(
    parameter W = 8,
    parameter AW = 8
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Write port
    input wire we_i,
    input wire [AW-1:0] waddr_i,
    input wire [W-1:0] wdata_i,
    // Read port
    input wire re_i,
    input wire [AW-1:0] raddr_i,
    output reg [W-1:0] rdata_o
);

    reg [W-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= {W{1'b0}};
        end else if (re_i) begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule

`default_nettype wire

// ===== verilog/ufb_buf2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module ufb_buf2 #(
    parameter W = 8
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    // Drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);

    reg [W-1:0] d0_reg;
    reg [W-1:0] d1_reg;
    reg [1:0] cnt_reg;
    wire push;
    wire pop;

    assign in_ready_o = (cnt_reg != 2'h2);
    assign out_valid_o = (cnt_reg != 2'h0);
    assign out_data_o = d0_reg;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            d0_reg <= {W{1'b0}};
            d1_reg <= {W{1'b0}};
            cnt_reg <= 2'h0;
        end else begin
            if (pop) begin
                if (cnt_reg == 2'h2) begin
                    d0_reg <= d1_reg;
                end else if (push) begin
                    d0_reg <= in_data_i;
                end
            end else if (push) begin
                if (cnt_reg == 2'h0) begin
                    d0_reg <= in_data_i;
                end else begin
                    d1_reg <= in_data_i;
                end
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 2'h1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

// ===== verilog/ufb_top.v
// Two-channel UART data port with FIFOs and fractional baud generators
`timescale 1ns/1ps
`default_nettype none
`include "ufb_defs.vh"

// Overview of operation
// R1: Every channel owns a 256-byte transmit FIFO and a 256-byte receive FIFO.
// R2: Full 32-bit reads and writes are accepted anywhere in the map.
// R3: Wide data windows take 8 to 32-bit accesses, one byte per enabled lane.
// R4: Channel N decodes FIFO page 4N+1 and status pages 4N+2 and 4N+3.
// R5: FIFO page reads pop receive bytes and writes push transmit bytes.
// R6: Wide receive read returns oldest byte in lane 0, newer bytes upward.
// R7: Wide transmit write queues lane 0 first and lane 3 last.
// R8: Status page returns status in low lane, data in high lane, per half.
// R9: Host reads the status page only with 16 or 32-bit accesses.
// R10: Holding location moves exactly one byte per access, lane 0 only.
// R11: Host reads line status separately before each holding byte read.
// R12: Prescaler divides the clock by 4 when modem-control bit 7 set, else 1.
// R13: Baud generator divides by 1 to 65536 minus 1/16 in 1/16 steps.
// R14: One sampling tick times both transmitter and receiver of a channel.
// R15: Reset gives divisor 1: low 0x01, high 0x00, fraction 0x00.
// R16: Only four fraction bits are kept; they add k sixteenths.
// R17: Integer divisor is high byte in bits 15:8, low byte in 7:0.
// R18: Odd fractions may cause at most one sixteenth of bit-time jitter.
// R19: FIFO pointers advance by exactly the bytes actually moved.
// R20: Each status half pops one byte and returns its captured status.
module ufb_top #(
    parameter [8:0] FIFO_DEPTH = `UFB_FIFO_DEPTH
) (
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // Host register port
    input wire host_req_i,
    input wire host_wr_i,
    input wire [`UFB_ADDR_W-1:0] host_addr_i,
    input wire [3:0] host_be_i,
    input wire [31:0] host_wdata_i,
    output wire host_ready_o,
    output reg host_ack_o,
    output reg [31:0] host_rdata_o,
    // Transmit byte streams, one lane per channel
    output wire [15:0] tx_data_o,
    output wire [1:0] tx_valid_o,
    input wire [1:0] tx_ready_i,
    // Receive byte streams with line status
    input wire [15:0] rx_data_i,
    input wire [15:0] rx_status_i,
    input wire [1:0] rx_valid_i,
    output wire [1:0] rx_ready_o,
    // Sampling clock ticks
    output wire [1:0] sample_tick_o
);
    localparam NUM_CH = 2;
    localparam AW = `UFB_FIFO_AW;
    localparam ST_IDLE = 2'h0;
    localparam ST_STEP = 2'h1;
    localparam ST_FIN = 2'h2;
    localparam ST_ACK = 2'h3;
    // ==========================================================
    // Access sequencer state
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg wr_reg;
    reg [`UFB_ADDR_W-1:0] addr_reg;
    reg [3:0] be_reg;
    reg [31:0] wdata_reg;
    reg [1:0] lane_reg;
    reg cap_valid_reg;
    reg cap_ch_reg;
    reg [1:0] cap_lane_reg;
    reg cap_stat_reg;
    wire [1:0] page;
    wire cur_ch;
    wire [7:0] cur_off;
    wire is_stat;
    wire is_fifo;
    wire is_hold;
    wire is_regs;
    wire lane_on;
    wire last_lane;
    wire [7:0] cur_wbyte;
    wire in_step;
    wire [NUM_CH-1:0] tx_full;
    wire [NUM_CH-1:0] rx_empty;
    wire [NUM_CH-1:0] host_push;
    wire [NUM_CH-1:0] host_pop;
    wire [NUM_CH*16-1:0] rx_q_all;
    wire [NUM_CH*8-1:0] div_low_all;
    wire [NUM_CH*8-1:0] div_high_all;
    wire [NUM_CH*4-1:0] div_frac_all;
    wire [NUM_CH*8-1:0] modem_all;
    // Channel on bit 10, page M = 4N+1 for FIFO, next two for status
    assign page = addr_reg[9:8]; // R4
    assign cur_ch = addr_reg[`UFB_CH_BIT];
    assign cur_off = {addr_reg[7:2], lane_reg};
    assign is_stat = page[1]; // R4
    assign is_fifo = (page == `UFB_PAGE_FIFO); // R5
    assign is_hold = (page == `UFB_PAGE_REGS) && (cur_off == `UFB_OFF_HOLD); // R10
    assign is_regs = (page == `UFB_PAGE_REGS);
    assign in_step = (state_reg == ST_STEP);
    // Status halves are enabled by either lane of the half
    assign lane_on = is_stat ? (be_reg[{lane_reg[0], 1'b0}] | be_reg[{lane_reg[0], 1'b1}])
                             : be_reg[lane_reg]; // R3 R20
    assign last_lane = is_stat ? (lane_reg == `UFB_LAST_HALF)
                               : (lane_reg == `UFB_LAST_BYTE_LANE);
    assign cur_wbyte = wdata_reg[8*lane_reg +: 8];
    assign host_ready_o = (state_reg == ST_IDLE); // R2
    // ==========================================================
    // Sequencer: one lane or half per cycle, lowest lane first
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (host_req_i) begin
                    state_next = ST_STEP;
                end
            end
            ST_STEP: begin
                if (last_lane) begin
                    state_next = ST_FIN;
                end
            end
            ST_FIN: begin
                state_next = ST_ACK;
            end
            ST_ACK: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            wr_reg <= 1'b0;
            addr_reg <= {`UFB_ADDR_W{1'b0}};
            be_reg <= 4'h0;
            wdata_reg <= 32'h0000_0000;
            lane_reg <= 2'h0;
            cap_valid_reg <= 1'b0;
            cap_ch_reg <= 1'b0;
            cap_lane_reg <= 2'h0;
            cap_stat_reg <= 1'b0;
            host_ack_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            host_ack_o <= (state_next == ST_ACK);
            if (state_reg == ST_IDLE && host_req_i) begin
                wr_reg <= host_wr_i;
                addr_reg <= host_addr_i;
                be_reg <= host_be_i;
                wdata_reg <= host_wdata_i;
                lane_reg <= 2'h0;
            end else if (in_step) begin
                lane_reg <= lane_reg + 2'h1; // R6 R7
            end
            cap_valid_reg <= |host_pop;
            cap_ch_reg <= cur_ch;
            cap_lane_reg <= lane_reg;
            cap_stat_reg <= is_stat;
        end
    end
    // ==========================================================
    // Read data assembly
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_rdata_o <= 32'h0000_0000;
        end else begin
            if (state_reg == ST_IDLE && host_req_i) begin
                host_rdata_o <= 32'h0000_0000;
            end
            if (in_step && !wr_reg && lane_on && is_regs) begin
                case (cur_off)
                    `UFB_OFF_DIV_LOW: host_rdata_o[8*lane_reg +: 8] <= div_low_all[8*cur_ch +: 8];
                    `UFB_OFF_DIV_HIGH: host_rdata_o[8*lane_reg +: 8] <= div_high_all[8*cur_ch +: 8];
                    `UFB_OFF_DIV_FRAC: host_rdata_o[8*lane_reg +: 8] <=
                        {4'h0, div_frac_all[4*cur_ch +: 4]}; // R16
                    `UFB_OFF_MODEM_CTL: host_rdata_o[8*lane_reg +: 8] <= modem_all[8*cur_ch +: 8];
                    default: host_rdata_o[8*lane_reg +: 8] <= 8'h00;
                endcase
            end
            if (cap_valid_reg) begin
                if (cap_stat_reg) begin
                    // Status byte in the low lane, data in the high lane
                    host_rdata_o[16*cap_lane_reg[0] +: 16] <= rx_q_all[16*cap_ch_reg +: 16]; // R8
                end else begin
                    host_rdata_o[8*cap_lane_reg +: 8] <= rx_q_all[16*cap_ch_reg+8 +: 8]; // R6
                end
            end
        end
    end
    // ==========================================================
    // Per-channel FIFOs, registers and baud generator
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
            reg [AW-1:0] tx_wp_reg;
            reg [AW-1:0] tx_rp_reg;
            reg [AW:0] tx_cnt_reg;
            reg [AW-1:0] rx_wp_reg;
            reg [AW-1:0] rx_rp_reg;
            reg [AW:0] rx_cnt_reg;
            reg rd_pend_reg;
            reg [7:0] div_low_reg;
            reg [7:0] div_high_reg;
            reg [3:0] div_frac_reg;
            reg [7:0] modem_reg;
            reg [1:0] pre_cnt_reg;
            reg [20:0] acc_reg;
            reg tick_reg;
            wire sel;
            wire reg_wr;
            wire drain_rd;
            wire buf_ready;
            wire [7:0] tx_q;
            wire rx_push;
            wire pre_tick;
            wire [15:0] div_int;
            wire [20:0] div16;
            wire [20:0] acc_sum;
            assign sel = (cur_ch == g);
            assign tx_full[g] = (tx_cnt_reg == FIFO_DEPTH);
            assign rx_empty[g] = (rx_cnt_reg == {(AW+1){1'b0}});
            // Full transmit FIFO drops the byte and leaves the pointer
            assign host_push[g] = in_step && sel && wr_reg && lane_on
                                  && (is_fifo || is_hold) && !tx_full[g]; // R5 R10 R19
            // Empty receive FIFO reads zero without popping
            assign host_pop[g] = in_step && sel && !wr_reg && lane_on
                                 && (is_fifo || is_hold || is_stat) && !rx_empty[g]; // R5 R19 R20
            assign reg_wr = in_step && sel && wr_reg && lane_on && is_regs;
            assign rx_ready_o[g] = (rx_cnt_reg != FIFO_DEPTH);
            assign rx_push = rx_valid_i[g] & rx_ready_o[g];
            assign drain_rd = !rd_pend_reg && buf_ready && (tx_cnt_reg != {(AW+1){1'b0}});
            assign div_low_all[8*g +: 8] = div_low_reg;
            assign div_high_all[8*g +: 8] = div_high_reg;
            assign div_frac_all[4*g +: 4] = div_frac_reg;
            assign modem_all[8*g +: 8] = modem_reg;
            ufb_ram #(
                .W(8),
                .AW(AW)
            ) u_tx_ram (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .we_i(host_push[g]),
                .waddr_i(tx_wp_reg),
                .wdata_i(cur_wbyte),
                .re_i(drain_rd),
                .raddr_i(tx_rp_reg),
                .rdata_o(tx_q)
            ); // R1
            ufb_ram #(
                .W(16),
                .AW(AW)
            ) u_rx_ram (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .we_i(rx_push),
                .waddr_i(rx_wp_reg),
                .wdata_i({rx_data_i[8*g +: 8], rx_status_i[8*g +: 8]}),
                .re_i(host_pop[g]),
                .raddr_i(rx_rp_reg),
                .rdata_o(rx_q_all[16*g +: 16])
            ); // R1 R20
            ufb_buf2 #(
                .W(8)
            ) u_tx_buf (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .in_valid_i(rd_pend_reg),
                .in_ready_o(buf_ready),
                .in_data_i(tx_q),
                .out_valid_o(tx_valid_o[g]),
                .out_ready_i(tx_ready_i[g]),
                .out_data_o(tx_data_o[8*g +: 8])
            );
            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    tx_wp_reg <= {AW{1'b0}};
                    tx_rp_reg <= {AW{1'b0}};
                    tx_cnt_reg <= {(AW+1){1'b0}};
                    rx_wp_reg <= {AW{1'b0}};
                    rx_rp_reg <= {AW{1'b0}};
                    rx_cnt_reg <= {(AW+1){1'b0}};
                    rd_pend_reg <= 1'b0;
                end else begin
                    rd_pend_reg <= drain_rd;
                    if (host_push[g]) begin
                        tx_wp_reg <= tx_wp_reg + 1'b1; // R19
                    end
                    if (drain_rd) begin
                        tx_rp_reg <= tx_rp_reg + 1'b1;
                    end
                    if (host_push[g] && !drain_rd) begin
                        tx_cnt_reg <= tx_cnt_reg + 1'b1;
                    end else if (drain_rd && !host_push[g]) begin
                        tx_cnt_reg <= tx_cnt_reg - 1'b1;
                    end
                    if (rx_push) begin
                        rx_wp_reg <= rx_wp_reg + 1'b1;
                    end
                    if (host_pop[g]) begin
                        rx_rp_reg <= rx_rp_reg + 1'b1; // R19
                    end
                    if (rx_push && !host_pop[g]) begin
                        rx_cnt_reg <= rx_cnt_reg + 1'b1;
                    end else if (host_pop[g] && !rx_push) begin
                        rx_cnt_reg <= rx_cnt_reg - 1'b1;
                    end
                end
            end
            // Divisor and modem-control registers
            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    div_low_reg <= `UFB_RST_DIV_LOW; // R15
                    div_high_reg <= `UFB_RST_DIV_HIGH; // R15
                    div_frac_reg <= `UFB_RST_DIV_FRAC; // R15
                    modem_reg <= `UFB_RST_MODEM_CTL;
                end else if (reg_wr) begin
                    case (cur_off)
                        `UFB_OFF_DIV_LOW: div_low_reg <= cur_wbyte;
                        `UFB_OFF_DIV_HIGH: div_high_reg <= cur_wbyte;
                        `UFB_OFF_DIV_FRAC: div_frac_reg <= cur_wbyte[`UFB_FRAC_W-1:0]; // R16
                        `UFB_OFF_MODEM_CTL: modem_reg <= cur_wbyte;
                        default: modem_reg <= modem_reg;
                    endcase
                end
            end
            // Prescaler then fractional divider counted in sixteenths
            assign pre_tick = modem_reg[`UFB_MCR_PRESCALE_BIT] ?
                              (pre_cnt_reg == `UFB_PRESCALE_LAST) : 1'b1; // R12
            assign div_int = {div_high_reg, div_low_reg}; // R17
            // Integer zero is held at the lowest legal divisor of 1
            assign div16 = {1'b0, (div_int == 16'h0000) ? 16'h0001 : div_int,
                            div_frac_reg}; // R13 R16
            assign acc_sum = acc_reg + `UFB_FRAC_STEP;
            assign sample_tick_o[g] = tick_reg; // R14
            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    pre_cnt_reg <= 2'h0;
                    acc_reg <= 21'h000000;
                    tick_reg <= 1'b0;
                end else begin
                    pre_cnt_reg <= pre_cnt_reg + 2'h1;
                    tick_reg <= 1'b0;
                    if (pre_tick) begin
                        // Remainder carries over, so jitter stays within one input period
                        if (acc_sum >= div16) begin
                            acc_reg <= acc_sum - div16; // R13 R18
                            tick_reg <= 1'b1;
                        end else begin
                            acc_reg <= acc_sum;
                        end
                    end
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

// ===== tb/ufb_top_assertions.sv
// Concurrent checks on host port and streams
`timescale 1ns/1ps
`default_nettype none
module ufb_assert_chk (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Host port
    input wire logic host_req_i,
    input wire logic [10:0] host_addr_i,
    input wire logic host_ready_o,
    input wire logic host_ack_o,
    input wire logic [31:0] host_rdata_o,
    // Streams and ticks
    input wire logic [15:0] tx_data_o,
    input wire logic [1:0] tx_valid_o,
    input wire logic [1:0] tx_ready_i,
    input wire logic [1:0] sample_tick_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    wire logic take = host_req_i && host_ready_o;
    // ==========================================
    // Host port timing
    AST_BYTE_LAT: assert property (take && !host_addr_i[9] |-> ##6 host_ack_o)
        else $error("byte window ack late or early");
    AST_STAT_LAT: assert property (take && host_addr_i[9] |-> ##4 host_ack_o)
        else $error("status window ack late or early");
    AST_ACK_ONE: assert property (host_ack_o |=> !host_ack_o)
        else $error("ack longer than one cycle");
    AST_BUSY: assert property (take |=> !host_ready_o [*3])
        else $error("ready back too soon after take");
    AST_READY_BACK: assert property (host_ack_o |-> !host_ready_o ##1 host_ready_o)
        else $error("ready not restored after ack");
    AST_RDATA_HOLD: assert property (host_ready_o && !host_req_i |=> $stable(host_rdata_o))
        else $error("read data moved while idle");
    // ==========================================
    // Transmit streams hold until taken
    AST_TX0_HOLD: assert property (tx_valid_o[0] && !tx_ready_i[0]
        |=> tx_valid_o[0] && $stable(tx_data_o[7:0]))
        else $error("channel 0 byte lost under stall");
    AST_TX1_HOLD: assert property (tx_valid_o[1] && !tx_ready_i[1]
        |=> tx_valid_o[1] && $stable(tx_data_o[15:8]))
        else $error("channel 1 byte lost under stall");
    cover property (take && host_addr_i[9]);
    cover property (tx_valid_o[0] && !tx_ready_i[0]);
    cover property (sample_tick_o[0] ##1 !sample_tick_o[0]);
endmodule
`default_nettype wire

// ===== tb/ufb_line_model.sv
// Serial-side model: sinks transmit bytes, sources received bytes
`timescale 1ns/1ps
`default_nettype none
module ufb_line_model (
    // Clock and control
    input wire logic clk_sys_i,
    input wire logic stall_i,
    // Transmit side
    input wire logic [15:0] tx_data_i,
    input wire logic [1:0] tx_valid_i,
    output logic [1:0] tx_ready_o,
    // Receive side
    output logic [15:0] rx_data_o,
    output logic [15:0] rx_status_o,
    output logic [1:0] rx_valid_o,
    input wire logic [1:0] rx_ready_i
);
    logic [7:0] tx_q0[$];
    logic [7:0] tx_q1[$];
    logic [15:0] rx_q0[$];
    logic [15:0] rx_q1[$];
    initial begin
        tx_ready_o = 2'b00;
        rx_valid_o = 2'b00;
        rx_data_o = 16'h0000;
        rx_status_o = 16'h0000;
    end
    always @(posedge clk_sys_i) begin
        if (tx_valid_i[0] && tx_ready_o[0]) tx_q0.push_back(tx_data_i[7:0]);
        if (tx_valid_i[1] && tx_ready_o[1]) tx_q1.push_back(tx_data_i[15:8]);
        if (rx_valid_o[0] && rx_ready_i[0]) void'(rx_q0.pop_front());
        if (rx_valid_o[1] && rx_ready_i[1]) void'(rx_q1.pop_front());
        #1;
        tx_ready_o = {2{!stall_i}};
        rx_valid_o = {rx_q1.size() != 0, rx_q0.size() != 0};
        // Idle lanes show the inverse of the last value
        {rx_status_o[7:0], rx_data_o[7:0]} = rx_valid_o[0] ? rx_q0[0]
            : ~{rx_status_o[7:0], rx_data_o[7:0]};
        {rx_status_o[15:8], rx_data_o[15:8]} = rx_valid_o[1] ? rx_q1[0]
            : ~{rx_status_o[15:8], rx_data_o[15:8]};
    end
endmodule
`default_nettype wire

// ===== tb/tb_ufb_top.sv
// Self-checking bench for the UART FIFO port block
`timescale 1ns/1ps
`default_nettype none
module tb_ufb_top;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic host_req_i = 1'b0;
    logic host_wr_i = 1'b0;
    logic stall = 1'b0;
    logic [10:0] host_addr_i = 11'h000;
    logic [3:0] host_be_i = 4'h0;
    logic [31:0] host_wdata_i = 32'h00000000;
    logic [31:0] rd;
    logic [7:0] b;
    int num_errors = 0;
    int check_count = 0;
    wire host_ready_o;
    wire host_ack_o;
    wire [31:0] host_rdata_o;
    wire [15:0] tx_data_o;
    wire [1:0] tx_valid_o;
    wire [1:0] tx_ready_i;
    wire [15:0] rx_data_i;
    wire [15:0] rx_status_i;
    wire [1:0] rx_valid_i;
    wire [1:0] rx_ready_o;
    wire [1:0] sample_tick_o;

    always #4 clk_sys_i = ~clk_sys_i;

    ufb_top dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .host_req_i(host_req_i),
        .host_wr_i(host_wr_i), .host_addr_i(host_addr_i), .host_be_i(host_be_i),
        .host_wdata_i(host_wdata_i), .host_ready_o(host_ready_o), .host_ack_o(host_ack_o),
        .host_rdata_o(host_rdata_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
        .tx_ready_i(tx_ready_i), .rx_data_i(rx_data_i), .rx_status_i(rx_status_i),
        .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .sample_tick_o(sample_tick_o));
    ufb_line_model line_u (.clk_sys_i(clk_sys_i), .stall_i(stall), .tx_data_i(tx_data_o),
        .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready_i), .rx_data_o(rx_data_i),
        .rx_status_o(rx_status_i), .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o));

    task final_report;
        if (num_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        check_count++;
        if ((got & m) !== (exp & m)) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ==========================================
    // One host access, held until taken
    task bus(input logic wr, input logic [10:0] a, input logic [3:0] be,
        input logic [31:0] wd, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        #1;
        host_req_i = 1'b1;
        host_wr_i = wr;
        host_addr_i = a;
        host_be_i = be;
        host_wdata_i = wd;
        @(posedge clk_sys_i);
        while (host_ready_o !== 1'b1 && n < 20) begin
            @(posedge clk_sys_i);
            n++;
        end
        #1;
        host_req_i = 1'b0;
        while (host_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        if (n >= 20) begin
            num_errors++;
            final_report();
        end
        r = host_rdata_o;
    endtask

    task ticks(input logic [31:0] div, input int win, input int exp0);
        int c0;
        int c1;
        bus(1'b1, 11'h008, 4'hF, div, rd);
        repeat (300) @(posedge clk_sys_i);
        c0 = 0;
        c1 = 0;
        repeat (win) begin
            @(posedge clk_sys_i);
            #1;
            c0 += sample_tick_o[0];
            c1 += sample_tick_o[1];
        end
        chk(c0, exp0, ALL);
        chk(c1, win, ALL);
    endtask

    initial begin
        repeat (5) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        bus(1'b0, 11'h008, 4'hF, 32'h0, rd);
        chk(rd, 32'h00000001, ALL);
        bus(1'b0, 11'h408, 4'hF, 32'h0, rd);
        chk(rd, 32'h00000001, ALL);
        bus(1'b1, 11'h008, 4'h4, 32'h00F80000, rd);
        bus(1'b0, 11'h008, 4'hF, 32'h0, rd);
        chk(rd, 32'h00080001, ALL);
        ticks(32'h00000003, 48, 16);
        ticks(32'h00080003, 56, 16);
        ticks(32'h80000003, 48, 4);
        ticks(32'h00000100, 512, 2);
        // Transmit words queue behind a stall
        stall = 1'b1;
        bus(1'b1, 11'h100, 4'hF, 32'h44332211, rd);
        bus(1'b1, 11'h000, 4'h1, 32'hEEEEEE55, rd);
        bus(1'b1, 11'h1FC, 4'h3, 32'hEEEE7766, rd);
        bus(1'b1, 11'h500, 4'hF, 32'hDDCCBBAA, rd);
        chk(tx_valid_o, 2'b11, ALL);
        stall = 1'b0;
        repeat (60) @(posedge clk_sys_i);
        #1;
        chk(tx_valid_o, 2'b00, ALL);
        chk(line_u.tx_q0.size(), 7, ALL);
        chk(line_u.tx_q1.size(), 4, ALL);
        for (int i = 0; i < 7; i++) chk(line_u.tx_q0[i], 8'h11 * (i + 1), ALL);
        for (int i = 0; i < 4; i++) chk(line_u.tx_q1[i], 8'hAA + 8'h11 * i, ALL);
        // Receive paths
        for (int i = 0; i < 8; i++) line_u.rx_q0.push_back({8'(8'h60 + i), 8'(8'h10 + i)});
        line_u.rx_q1.push_back(16'h0199);
        line_u.rx_q1.push_back(16'h029A);
        repeat (20) @(posedge clk_sys_i);
        bus(1'b0, 11'h100, 4'hF, 32'h0, rd);
        chk(rd, 32'h13121110, ALL);
        bus(1'b0, 11'h000, 4'h1, 32'h0, rd);
        chk(rd, 32'h00000014, 32'h000000FF);
        bus(1'b0, 11'h200, 4'hF, 32'h0, rd);
        chk(rd, 32'h16661565, ALL);
        bus(1'b0, 11'h104, 4'h1, 32'h0, rd);
        chk(rd, 32'h00000017, 32'h000000FF);
        bus(1'b0, 11'h100, 4'hF, 32'h0, rd);
        chk(rd, 32'h00000000, ALL);
        bus(1'b0, 11'h600, 4'h3, 32'h0, rd);
        chk(rd, 32'h00009901, 32'h0000FFFF);
        bus(1'b0, 11'h500, 4'h1, 32'h0, rd);
        chk(rd, 32'h0000009A, 32'h000000FF);
        // Receive FIFO fills and refuses one more
        for (int i = 0; i < 257; i++) line_u.rx_q0.push_back({8'h00, 8'(i + 1)});
        repeat (300) @(posedge clk_sys_i);
        #1;
        chk(rx_ready_o, 2'b10, ALL);
        chk(line_u.rx_q0.size(), 1, ALL);
        for (int k = 0; k < 64; k++) begin
            b = 8'(4 * k + 1);
            bus(1'b0, 11'h100, 4'hF, 32'h0, rd);
            chk(rd, {b + 8'h3, b + 8'h2, b + 8'h1, b}, ALL);
        end
        repeat (10) @(posedge clk_sys_i);
        bus(1'b0, 11'h000, 4'h1, 32'h0, rd);
        chk(rd, 32'h00000001, 32'h000000FF);
        final_report();
    end
endmodule

bind ufb_top ufb_assert_chk chk_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .host_req_i(host_req_i), .host_addr_i(host_addr_i), .host_ready_o(host_ready_o),
    .host_ack_o(host_ack_o), .host_rdata_o(host_rdata_o), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .sample_tick_o(sample_tick_o));
`default_nettype wire
